// [rtl/mbpm_pkg.sv]
// Constants, types and register map of the parameter mapping and timeout block
`default_nettype none
// Function
// - Reference multiplied, actual value divided, by scale setting plus one.
// - Scaling only with transparent 16 profile, native profile and 16-bit values.
// - Timeout value setting of zero disables supervision.
// - Timeout period is setting times 100 ms; reset value 20.
// - On expiry, signal the drive that client communication is lost.
// - Restart selection 0 keeps timeout supervision disabled.
// - Restart selection 1 restarts counter on any register access.
// - Restart selection 2 restarts on new control word or references.
// - Each 16-bit register sends high byte first, low byte second.
// - Word order 0: low word in first register, high word second.
// - Word order 1 (default): high word first, low word second.
// - Address mode selects parameter mapping; reset mode 0.
// - Mode 0 16-bit: register is 100*group plus index, up to 99.
// - Mode 0 32-bit: register is 20000 plus 200*group plus 2*index.
// - Mode 1 16-bit: register is 256*group plus index, up to 255.
// - Mode 1 has no 32-bit parameter mapping.
// - Mode 2 32-bit: 512*group plus 2*index, group to 127, index 255.
// - Mode 3 32-bit: 256*group plus 2*index, group to 255, index 127.
package mbpm_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0]  ADDR_SCALE    = 8'h00;
   localparam logic [7:0]  ADDR_TMO_VAL  = 8'h04;
   localparam logic [7:0]  ADDR_TMO_MODE = 8'h08;
   localparam logic [7:0]  ADDR_WORD_ORD = 8'h0c;
   localparam logic [7:0]  ADDR_ADR_MODE = 8'h10;
   localparam logic [7:0]  ADDR_CTRL     = 8'h14;
   localparam logic [7:0]  ADDR_STATUS   = 8'h18;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h1c;
   localparam logic [7:0]  ADDR_IRQ_MASK = 8'h20;
   localparam logic [15:0] RST_SCALE     = 16'h0063;
   localparam logic [15:0] RST_TMO_VAL   = 16'h0014;
   localparam logic [15:0] RST_TMO_MODE  = 16'h0002;
   localparam logic [15:0] RST_WORD_ORD  = 16'h0001;
   localparam logic [15:0] RST_ADR_MODE  = 16'h0000;
   // Control register bits
   localparam int CTRL_T16   = 0;
   localparam int CTRL_NAT   = 1;
   localparam int CTRL_REF16 = 2;
   // Interrupt status bits
   localparam int IRQ_LOST  = 0;
   localparam int IRQ_NOMAP = 1;
   localparam int IRQ_W     = 2;
   // Restart selections and word orders
   localparam logic [15:0] TMO_NONE  = 16'h0000;
   localparam logic [15:0] TMO_ANY   = 16'h0001;
   localparam logic [15:0] TMO_CTRL  = 16'h0002;
   localparam logic [15:0] LOW_WORD_FIRST  = 16'h0000;
   localparam logic [15:0] HIGH_WORD_FIRST = 16'h0001;
   // Address mapping constants
   localparam logic [15:0] M0_MUL16  = 16'h0064;
   localparam logic [15:0] M0_BASE32 = 16'h4e20;
   localparam logic [15:0] M0_MUL32  = 16'h00c8;
   localparam logic [15:0] M0_MAX    = 16'h0063;
   localparam logic [15:0] M1_MUL    = 16'h0100;
   localparam logic [15:0] M2_MUL    = 16'h0200;
   localparam logic [15:0] M2_GMAX   = 16'h007f;
   localparam logic [15:0] M1_MAX    = 16'h00ff;
   // Timing
   localparam int CLK_HZ      = 40_000_000;
   localparam int TICK_MS     = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // Mapping request and answer
   typedef struct packed {
      logic [7:0] group;
      logic [7:0] index;
      logic       wide;
   } mbpm_map_req_t;
   typedef struct packed {
      logic [15:0] reg_addr;
      logic        valid;
   } mbpm_map_ans_t;
   // Wishbone request
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } mbpm_wb_req_t;
endpackage
`default_nettype wire

// [rtl/mbpm_top.sv]
// Parameter mapping, reference scaling and client timeout supervision
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mbpm_top #(
   parameter int TICK_CYC = mbpm_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Wishbone slave
   input  wire mbpm_pkg::mbpm_wb_req_t  wb_req,
   output var  logic [31:0]             wb_dat_o,
   output var  logic                    wb_ack_o,
   output var  logic                    irq,
   // Client access events
   input  wire logic                    acc_any,
   input  wire logic                    acc_ctrl,
   input  wire logic                    acc_first_reference,
   input  wire logic                    acc_second_reference,
   output var  logic                    comm_lost,
   // Reference and actual value
   input  wire logic [15:0]             ref_in,
   output var  logic [31:0]             ref_out,
   input  wire logic [31:0]             act_in,
   output var  logic [15:0]             act_out,
   // Address mapping
   input  wire logic                    map_go,
   input  wire mbpm_pkg::mbpm_map_req_t map_req,
   output var  mbpm_pkg::mbpm_map_ans_t map_ans,
   output var  logic                    map_done,
   // Word ordering and byte serialising
   input  wire logic [31:0]             val32,
   output var  logic [15:0]             reg_first,
   output var  logic [15:0]             reg_second,
   input  wire logic [15:0]             ser_word,
   input  wire logic                    ser_sel,
   output var  logic [7:0]              ser_byte
);
   import mbpm_pkg::*;

   // ==========================================================
   // Register file
   logic [15:0] scale_r, tmo_val_r, tmo_mode_r, word_ord_r, adr_mode_r;
   logic [2:0]  ctrl_r;
   logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
   logic        wb_hit, wb_wr, wb_rd_stat;
   logic [31:0] rd_nxt;
   logic        tmo_run;

   assign wb_hit     = wb_req.cyc && wb_req.stb && !wb_ack_o;
   assign wb_wr      = wb_hit && wb_req.we;
   assign wb_rd_stat = wb_hit && !wb_req.we && (wb_req.adr == ADDR_IRQ_STAT);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scale_r    <= RST_SCALE;
         tmo_val_r  <= RST_TMO_VAL;
         tmo_mode_r <= RST_TMO_MODE;
         word_ord_r <= RST_WORD_ORD;
         adr_mode_r <= RST_ADR_MODE;
         ctrl_r     <= 3'h0;
         irq_mask_r <= '0;
      end else if (wb_wr) begin
         if (wb_req.adr == ADDR_SCALE) begin
            if (wb_req.sel[0]) scale_r[7:0] <= wb_req.dat[7:0];
            if (wb_req.sel[1]) scale_r[15:8] <= wb_req.dat[15:8];
         end else if (wb_req.adr == ADDR_TMO_VAL) begin
            if (wb_req.sel[0]) tmo_val_r[7:0] <= wb_req.dat[7:0];
            if (wb_req.sel[1]) tmo_val_r[15:8] <= wb_req.dat[15:8];
         end else if (wb_req.adr == ADDR_TMO_MODE) begin
            if (wb_req.sel[0]) tmo_mode_r[7:0] <= wb_req.dat[7:0];
            if (wb_req.sel[1]) tmo_mode_r[15:8] <= wb_req.dat[15:8];
         end else if (wb_req.adr == ADDR_WORD_ORD) begin
            if (wb_req.sel[0]) word_ord_r[7:0] <= wb_req.dat[7:0];
            if (wb_req.sel[1]) word_ord_r[15:8] <= wb_req.dat[15:8];
         end else if (wb_req.adr == ADDR_ADR_MODE) begin
            if (wb_req.sel[0]) adr_mode_r[7:0] <= wb_req.dat[7:0];
            if (wb_req.sel[1]) adr_mode_r[15:8] <= wb_req.dat[15:8];
         end else if (wb_req.adr == ADDR_CTRL) begin
            if (wb_req.sel[0]) ctrl_r <= wb_req.dat[2:0];
         end else if (wb_req.adr == ADDR_IRQ_MASK) begin
            if (wb_req.sel[0]) irq_mask_r <= wb_req.dat[IRQ_W-1:0];
         end
      end
   end

   // Read mux; unmapped addresses read zero and are still acknowledged
   always_comb begin
      rd_nxt = 32'h0;
      if (wb_req.adr == ADDR_SCALE) begin
         rd_nxt[15:0] = scale_r;
      end else if (wb_req.adr == ADDR_TMO_VAL) begin
         rd_nxt[15:0] = tmo_val_r;
      end else if (wb_req.adr == ADDR_TMO_MODE) begin
         rd_nxt[15:0] = tmo_mode_r;
      end else if (wb_req.adr == ADDR_WORD_ORD) begin
         rd_nxt[15:0] = word_ord_r;
      end else if (wb_req.adr == ADDR_ADR_MODE) begin
         rd_nxt[15:0] = adr_mode_r;
      end else if (wb_req.adr == ADDR_CTRL) begin
         rd_nxt[2:0] = ctrl_r;
      end else if (wb_req.adr == ADDR_STATUS) begin
         rd_nxt[0] = comm_lost;
         rd_nxt[1] = tmo_run;
      end else if (wb_req.adr == ADDR_IRQ_STAT) begin
         rd_nxt[IRQ_W-1:0] = irq_stat_r;
      end else if (wb_req.adr == ADDR_IRQ_MASK) begin
         rd_nxt[IRQ_W-1:0] = irq_mask_r;
      end
   end

   // One-wait-state answer: ack one cycle after the strobe is seen
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_hit;
         if (wb_hit && !wb_req.we) wb_dat_o <= rd_nxt;
      end
   end

   // Sticky events; a new event wins over the read-clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= '0;
         irq        <= 1'b0;
      end else begin
         irq_stat_r <= (wb_rd_stat ? '0 : irq_stat_r) | irq_set;
         irq        <= |(((wb_rd_stat ? '0 : irq_stat_r) | irq_set) & irq_mask_r);
      end
   end

   // ==========================================================
   // Timeout supervision
   logic        restart;
   logic        tmo_en;
   logic [31:0] tick_cnt_r;
   logic [15:0] tick_num_r;
   logic        lost_evt;

   assign tmo_en  = (tmo_val_r != 16'h0) && (tmo_mode_r != TMO_NONE);
   always_comb begin
      restart = 1'b0;
      if (tmo_mode_r == TMO_ANY) begin
         restart = acc_any;
      end else if (tmo_mode_r == TMO_CTRL) begin
         restart = acc_ctrl || acc_first_reference || acc_second_reference;
      end
   end
   assign lost_evt = tmo_run && tmo_en && !restart && (tick_cnt_r == 32'(TICK_CYC - 1))
                     && (tick_num_r + 16'h1 >= tmo_val_r);

   // Counts 100 ms ticks since the last restart, then idles
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tmo_run    <= 1'b0;
         tick_cnt_r <= 32'h0;
         tick_num_r <= 16'h0;
      end else if (!tmo_en) begin
         tmo_run    <= 1'b0;
         tick_cnt_r <= 32'h0;
         tick_num_r <= 16'h0;
      end else if (restart) begin
         tmo_run    <= 1'b1;
         tick_cnt_r <= 32'h0;
         tick_num_r <= 16'h0;
      end else if (lost_evt) begin
         tmo_run    <= 1'b0;
      end else if (tmo_run) begin
         if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
            tick_cnt_r <= 32'h0;
            tick_num_r <= tick_num_r + 16'h1;
         end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
         end
      end
   end

   // Loss level held until a qualifying access restarts supervision or supervision is disabled
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         comm_lost <= 1'b0;
      end else if (lost_evt) begin
         comm_lost <= 1'b1;
      end else if (restart || !tmo_en) begin
         comm_lost <= 1'b0;
      end
   end

   // ==========================================================
   // Reference scaling
   logic scale_on;
   logic [16:0] scale_div;
   assign scale_on  = ctrl_r[CTRL_T16] && ctrl_r[CTRL_NAT] && ctrl_r[CTRL_REF16];
   assign scale_div = {1'b0, scale_r} + 17'h1;

   // Divider is combinational with a registered result; a trade of area for one-cycle latency
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ref_out <= 32'h0;
         act_out <= 16'h0;
      end else if (scale_on) begin
         ref_out <= 32'({16'h0, ref_in} * {15'h0, scale_div});
         act_out <= 16'(act_in / {15'h0, scale_div});
      end else begin
         ref_out <= {16'h0, ref_in};
         act_out <= act_in[15:0];
      end
   end

   // ==========================================================
   // Word and byte ordering
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_first  <= 16'h0;
         reg_second <= 16'h0;
         ser_byte   <= 8'h0;
      end else begin
         if (word_ord_r == LOW_WORD_FIRST) begin
            reg_first  <= val32[15:0];
            reg_second <= val32[31:16];
         end else begin
            reg_first  <= val32[31:16];
            reg_second <= val32[15:0];
         end
         ser_byte <= ser_sel ? ser_word[7:0] : ser_word[15:8];
      end
   end

   // ==========================================================
   // Parameter to register address mapping
   mbpm_map_ans_t map_nxt;
   logic [15:0]   g, ix;
   assign g  = {8'h0, map_req.group};
   assign ix = {8'h0, map_req.index};

   always_comb begin
      map_nxt = '0;
      case (adr_mode_r)
         16'h0000: begin
            map_nxt.valid = (g <= M0_MAX) && (ix <= M0_MAX);
            if (map_req.wide) begin
               map_nxt.reg_addr = 16'(M0_BASE32 + M0_MUL32 * g + (ix << 1));
            end else begin
               map_nxt.reg_addr = 16'(M0_MUL16 * g + ix);
            end
         end
         16'h0001: begin
            map_nxt.valid    = !map_req.wide;
            map_nxt.reg_addr = map_req.wide ? 16'h0 : 16'(M1_MUL * g + ix);
         end
         16'h0002: begin
            map_nxt.valid    = map_req.wide && (g <= M2_GMAX);
            map_nxt.reg_addr = map_req.wide ? 16'(M2_MUL * g + (ix << 1)) : 16'h0;
         end
         16'h0003: begin
            map_nxt.valid    = map_req.wide && (ix <= M2_GMAX);
            map_nxt.reg_addr = map_req.wide ? 16'(M1_MUL * g + (ix << 1)) : 16'h0;
         end
         default: begin
            map_nxt = '0;
         end
      endcase
   end

   assign irq_set[IRQ_LOST]  = lost_evt;
   assign irq_set[IRQ_NOMAP] = map_go && !map_nxt.valid;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         map_ans  <= '0;
         map_done <= 1'b0;
      end else begin
         map_done <= map_go;
         if (map_go) map_ans <= map_nxt;
      end
   end
endmodule
`default_nettype wire

// [dv/mbpm_checker.sv]
// Port assertions for the mapping and timeout block
`timescale 1ns/10ps
`default_nettype none
module mbpm_checker
   import mbpm_pkg::*;
#(
   parameter int TICK_CYC = 10
) (
   // Clock, reset and observed ports
   input wire logic                    sys_clk,
   input wire logic                    rst,
   input wire mbpm_pkg::mbpm_wb_req_t  wb_req,
   input wire logic                    wb_ack_o,
   input wire logic                    acc_any,
   input wire logic                    acc_ctrl,
   input wire logic                    acc_first_reference,
   input wire logic                    acc_second_reference,
   input wire logic                    comm_lost,
   input wire logic                    map_go,
   input wire mbpm_pkg::mbpm_map_req_t map_req,
   input wire mbpm_pkg::mbpm_map_ans_t map_ans,
   input wire logic                    map_done,
   input wire logic [31:0]             val32,
   input wire logic [15:0]             reg_first,
   input wire logic [15:0]             reg_second,
   input wire logic [15:0]             ser_word,
   input wire logic                    ser_sel,
   input wire logic [7:0]              ser_byte
);
   // ==========================================
   // Mapping request one cycle back
   logic [7:0] grp_r;
   logic [7:0] idx_r;
   logic       wide_r;
   always_ff @(posedge sys_clk) begin
      grp_r  <= map_req.group;
      idx_r  <= map_req.index;
      wide_r <= map_req.wide;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // Properties
   sequence restart_s;
      acc_any && (acc_ctrl || acc_first_reference || acc_second_reference);
   endsequence
   // Even one tick needs more cycles than this quiet span
   sequence quiet_s;
      ##2 !comm_lost [*6];
   endsequence
   ack_pulse_a: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   map_lat_a: assert property (map_go |=> map_done) else $error("map answer late");
   map_quiet_a: assert property (!map_go |=> !map_done) else $error("stray map answer");
   byte_order_a: assert property (1'b1 |=>
      ser_byte == ($past(ser_sel) ? $past(ser_word[7:0]) : $past(ser_word[15:8])))
      else $error("wrong byte order");
   word_split_a: assert property (1'b1 |=>
      {reg_first, reg_second} == $past(val32) || {reg_second, reg_first} == $past(val32))
      else $error("word split wrong");
   map_narrow_a: assert property (map_done && map_ans.valid && !wide_r |->
      map_ans.reg_addr == 16'(grp_r * 100 + idx_r) || map_ans.reg_addr == 16'(grp_r * 256 + idx_r))
      else $error("narrow address wrong");
   map_wide_a: assert property (map_done && map_ans.valid && wide_r |->
      map_ans.reg_addr == 16'(20000 + grp_r * 200 + idx_r * 2) ||
      map_ans.reg_addr == 16'(grp_r * 512 + idx_r * 2) || map_ans.reg_addr == 16'(grp_r * 256 + idx_r * 2))
      else $error("wide address wrong");
   lost_hold_a: assert property ((restart_s and (TICK_CYC >= 8)) |-> quiet_s)
      else $error("loss flagged right after restart");
endmodule
bind mbpm_top mbpm_checker #(.TICK_CYC(TICK_CYC)) u_chk (
   .sys_clk, .rst, .wb_req, .wb_ack_o, .acc_any, .acc_ctrl, .acc_first_reference, .acc_second_reference, .comm_lost, .map_go,
   .map_req, .map_ans, .map_done, .val32, .reg_first, .reg_second, .ser_word, .ser_sel, .ser_byte);
`default_nettype wire

// [dv/mbpm_client.sv]
// Client model: turns bench commands into register access events
`timescale 1ns/10ps
`default_nettype none
module mbpm_client (
   // Command: kind 0 other register, 1 control word, 2 and 3 references
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   // Access events
   output var  logic       acc_any,
   output var  logic       acc_ctrl,
   output var  logic       acc_first_reference,
   output var  logic       acc_second_reference
);
   // A control word or reference write is itself a register access
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {acc_any, acc_ctrl, acc_first_reference, acc_second_reference} <= 4'h0;
      end else begin
         acc_any  <= go;
         acc_ctrl <= go && kind == 2'h1;
         acc_first_reference <= go && kind == 2'h2;
         acc_second_reference <= go && kind == 2'h3;
      end
   end
endmodule
`default_nettype wire

// [dv/tb_modbus_param_mapping_timeout.sv]
// Self-checking bench for the mapping, scaling and timeout block
`timescale 1ns/10ps
`default_nettype none
module tb_modbus_param_mapping_timeout;
   import mbpm_pkg::*;
   logic                    sys_clk, rst, wb_ack_o, irq, comm_lost, map_go, map_done, ser_sel, go;
   logic                    acc_any, acc_ctrl, acc_first_reference, acc_second_reference;
   logic [1:0]              kind;
   logic [7:0]              ser_byte;
   logic [15:0]             ref_in, act_out, reg_first, reg_second, ser_word;
   logic [31:0]             wb_dat_o, ref_out, act_in, val32, v, a;
   mbpm_wb_req_t            wb_req;
   mbpm_map_req_t           map_req;
   mbpm_map_ans_t           map_ans;
   int                      failures, comparisons, r, s, m, j, g, i, wd, ev, ea;
   mbpm_top #(.TICK_CYC(10)) u_dut (.sys_clk, .rst, .wb_req, .wb_dat_o, .wb_ack_o, .irq, .acc_any, .acc_ctrl,
      .acc_first_reference, .acc_second_reference, .comm_lost, .ref_in, .ref_out, .act_in, .act_out, .map_go, .map_req, .map_ans,
      .map_done, .val32, .reg_first, .reg_second, .ser_word, .ser_sel, .ser_byte);
   mbpm_client u_cli (.sys_clk, .rst, .go, .kind, .acc_any, .acc_ctrl, .acc_first_reference, .acc_second_reference);
   always #12.5 sys_clk = ~sys_clk;
   // ==========================================
   // Tasks
   task automatic check(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge sys_clk);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, d};
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      q = wb_dat_o;
      check("wb ack", 32'(wb_ack_o), 32'h1);
      wb_req <= '0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, adr, d, q);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, adr, 32'h0, q);
      check(nm, q, e);
   endtask
   task automatic pulse(input int k);
      @(posedge sys_clk);
      go <= 1'b1;
      kind <= 2'(k);
      @(posedge sys_clk);
      go <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic summarize;
      $display("comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      {sys_clk, wb_req, map_go, map_req, ser_sel, go, kind, ref_in, act_in, val32, ser_word} = '0;
      rst = 1'b1;
      r = $urandom(95869);
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk("scale", ADDR_SCALE, 32'h63);
      rd_chk("tmo value", ADDR_TMO_VAL, 32'h14);
      rd_chk("tmo mode", ADDR_TMO_MODE, 32'h2);
      rd_chk("word order", ADDR_WORD_ORD, 32'h1);
      rd_chk("addr mode", ADDR_ADR_MODE, 32'h0);
      rd_chk("unmapped", 8'h40, 32'h0);
      $display("test reset done");
      wr(ADDR_CTRL, 32'h7);
      for (int k = 0; k < 6; k++) begin
         s = k == 0 ? 0 : (k == 4 ? 65535 : $urandom_range(1, 300));
         if (k == 5) wr(ADDR_CTRL, 32'h3);
         wr(ADDR_SCALE, s);
         r = $urandom_range(0, 65535);
         a = $urandom;
         @(posedge sys_clk);
         ref_in <= 16'(r);
         act_in <= a;
         settle(1);
         check("ref out", ref_out, k < 5 ? r * (s + 1) : r);
         check("act out", 32'(act_out), k < 5 ? 32'(16'(a / (s + 1))) : a & 32'hffff);
      end
      $display("test scaling done");
      for (int w = 0; w < 2; w++) begin
         wr(ADDR_WORD_ORD, w);
         v = $urandom;
         @(posedge sys_clk);
         val32 <= v;
         ser_word <= v[15:0];
         ser_sel <= w[0];
         settle(1);
         check("first reg", 32'(reg_first), w ? v[31:16] : v[15:0]);
         check("second reg", 32'(reg_second), w ? v[15:0] : v[31:16]);
         check("byte", 32'(ser_byte), w ? v[7:0] : v[15:8]);
      end
      $display("test order done");
      wr(ADDR_IRQ_MASK, 32'h2);
      for (int c = 0; c < 21; c++) begin
         j = c / 3;
         m = j < 4 ? j / 2 : j - 2;
         wd = j < 4 ? j % 2 : 1;
         g = $urandom_range(1, m == 0 ? 110 : 255);
         i = $urandom_range(1, m == 0 ? 110 : 255);
         wr(ADDR_ADR_MODE, m);
         @(posedge sys_clk);
         map_req <= '{8'(g), 8'(i), wd[0]};
         map_go <= 1'b1;
         @(posedge sys_clk);
         map_go <= 1'b0;
         #1;
         ev = 0;
         ea = wd ? 256 * g + 2 * i : 256 * g + i;
         case (m)
            0: begin
               ev = g <= 99 && i <= 99;
               ea = wd ? 20000 + 200 * g + 2 * i : 100 * g + i;
            end
            1: ev = !wd;
            2: begin
               ev = g <= 127;
               ea = 512 * g + 2 * i;
            end
            3: ev = i <= 127;
            default: ev = 0;
         endcase
         check("map valid", 32'(map_ans.valid), ev);
         if (ev) check("map addr", 32'(map_ans.reg_addr), ea & 32'hffff);
      end
      check("irq on", 32'(irq), 32'h1);
      rd_chk("irq status", ADDR_IRQ_STAT, 32'h2);
      settle(2);
      check("irq off", 32'(irq), 32'h0);
      $display("test mapping done");
      wr(ADDR_TMO_VAL, 32'h3);
      for (int md = 0; md < 4; md++) begin
         if (md == 3) wr(ADDR_TMO_VAL, 32'h0);
         wr(ADDR_TMO_MODE, md < 3 ? md : 2);
         pulse(md < 3 ? md + 1 : 1);
         repeat (12) @(posedge sys_clk);
         pulse(0);
         settle(13);
         check("lost early", 32'(comm_lost), 32'h0);
         settle(8);
         check("lost", 32'(comm_lost), md == 2);
         if (md == 2) begin
            check("irq masked", 32'(irq), 32'h0);
            rd_chk("status", ADDR_STATUS, 32'h1);
            wr(ADDR_IRQ_MASK, 32'h1);
            settle(1);
            check("irq lost", 32'(irq), 32'h1);
            rd_chk("irq lost bit", ADDR_IRQ_STAT, 32'h1);
         end
      end
      $display("test timeout done");
      summarize;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      summarize;
   end
endmodule
`default_nettype wire
